// ==== design/port_power_vconn_control.sv ====
// port power, vconn supply, vbus drain and overcurrent control
`timescale 1ns/1ps
`include "port_power_params.svh"
module port_power_vconn_control import port_power_pkg::*; #(
	parameter int DRAIN_CYCLES = `DRAIN_CYCLES
) (
	input wire logic clock,
	input wire logic reset_n,
	input wire cc_port_ctrl_t p1_ctrl,
	input wire cc_port_ctrl_t p2_ctrl,
	input wire cc_port_sense_t p1_sense,
	input wire cc_port_sense_t p2_sense,
	input wire logic p4_port_enable,
	input wire logic [`FAULT_W-1:0] fault_clear,
	output logic p1_cc1_supply_en,
	output logic p1_cc2_supply_en,
	output logic p1_vbus_drain_en,
	output logic p2_cc1_supply_en,
	output logic p2_cc2_supply_en,
	output logic p2_vbus_drain_en,
	input wire logic p4_power_en_oc_sense_in,
	output logic p4_power_en_oc_sense_out,
	output logic p4_power_en_oc_sense_oe,
	output logic p4_power_en_oc_sense_pu,
	output logic p4_usb2_power_on,
	output logic p4_usb3_power_on,
	output logic [`FAULT_W-1:0] fault_status,
	output logic [`FAULT_W-1:0] fault_live
);
	// a drain longer than the counter can hold would wrap into a short pulse
	localparam bit DRAIN_BAD = DRAIN_CYCLES < 1
		|| DRAIN_CYCLES >= (1 << `DRAIN_CNT_W);
	if (DRAIN_BAD) begin : g_bad_drain
		$error("DRAIN_CYCLES out of range");
	end

	logic rst_meta_ff, rst_sync_ff;
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			rst_meta_ff <= 1'b0;
			rst_sync_ff <= 1'b0;
		end else begin
			rst_meta_ff <= 1'b1;
			rst_sync_ff <= rst_meta_ff;
		end
	end
	wire rst_n = rst_sync_ff;

	// sense pins are analog comparator outputs from outside the clock domain
	logic [4:0] sense_meta_ff, sense_ff;
	wire [4:0] sense_raw = {p4_power_en_oc_sense_in,
		p2_sense.cc2_above_3v0, p2_sense.cc1_above_3v0,
		p1_sense.cc2_above_3v0, p1_sense.cc1_above_3v0};
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			sense_meta_ff <= 5'h1f;
			sense_ff <= 5'h1f;
		end else begin
			sense_meta_ff <= sense_raw;
			sense_ff <= sense_meta_ff;
		end
	end

	// per port vconn and drain logic for ports 1 and 2
	cc_port_ctrl_t ctrl [2];
	cc_port_pins_t pins [2];
	logic [1:0] drain_busy;
	assign ctrl[0] = p1_ctrl;
	assign ctrl[1] = p2_ctrl;

	genvar g;
	generate
		for (g = 0; g < 2; g++) begin : g_cc
			logic cc1_ff, cc2_ff;
			drain_state_t state_ff, nxt_state;
			logic [`DRAIN_CNT_W-1:0] cnt_ff, nxt_cnt;
			always_ff @(posedge clock or negedge rst_n) begin
				if (!rst_n) begin
					cc1_ff <= 1'b0;
					cc2_ff <= 1'b0;
					state_ff <= DRAIN_IDLE;
					cnt_ff <= '0;
				end else begin
					cc1_ff <= ctrl[g].cc1_on;
					cc2_ff <= ctrl[g].cc2_on;
					state_ff <= nxt_state;
					cnt_ff <= nxt_cnt;
				end
			end
			// drain pulse has fixed length; a stuck request restarts it after one idle cycle
			always_comb begin
				nxt_state = state_ff;
				nxt_cnt = cnt_ff;
				case (state_ff)
					DRAIN_IDLE: begin
						if (ctrl[g].drain_req) begin
							nxt_state = DRAIN_BUSY;
							nxt_cnt = `DRAIN_CNT_W'(DRAIN_CYCLES - 1);
						end
					end
					DRAIN_BUSY: begin
						if (cnt_ff == '0)
							nxt_state = DRAIN_IDLE;
						else
							nxt_cnt = cnt_ff - `DRAIN_CNT_W'(1);
					end
					default: begin
						nxt_state = DRAIN_IDLE;
						nxt_cnt = '0;
					end
				endcase
			end
			assign drain_busy[g] = (state_ff == DRAIN_BUSY);
			assign pins[g] = '{cc1_ff, cc2_ff, drain_busy[g]};
		end
	endgenerate

	assign p1_cc1_supply_en = pins[0].cc1_supply_en;
	assign p1_cc2_supply_en = pins[0].cc2_supply_en;
	assign p1_vbus_drain_en = pins[0].vbus_drain_en;
	assign p2_cc1_supply_en = pins[1].cc1_supply_en;
	assign p2_cc2_supply_en = pins[1].cc2_supply_en;
	assign p2_vbus_drain_en = pins[1].vbus_drain_en;

	// port 4 shared pin
	logic p4_en_ff;
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n)
			p4_en_ff <= 1'b0;
		else
			p4_en_ff <= p4_port_enable;
	end
	assign p4_power_en_oc_sense_oe = !p4_en_ff;
	assign p4_power_en_oc_sense_out = 1'b0;
	assign p4_power_en_oc_sense_pu = p4_en_ff;
	// one pin, one power state for both halves
	assign p4_usb2_power_on = p4_en_ff;
	assign p4_usb3_power_on = p4_en_ff;

	// live faults; sense settles after enable so two stages of lag are expected
	wire oc_live = p4_en_ff && !sense_ff[4];
	assign fault_live[`FAULT_P1_CC1] = pins[0].cc1_supply_en && !sense_ff[0];
	assign fault_live[`FAULT_P1_CC2] = pins[0].cc2_supply_en && !sense_ff[1];
	assign fault_live[`FAULT_P2_CC1] = pins[1].cc1_supply_en && !sense_ff[2];
	assign fault_live[`FAULT_P2_CC2] = pins[1].cc2_supply_en && !sense_ff[3];
	assign fault_live[`FAULT_P4_OC] = oc_live;

	// sticky status: set wins over clear
	logic [`FAULT_W-1:0] status_ff;
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n)
			status_ff <= '0;
		else
			status_ff <= (status_ff & ~fault_clear) | fault_live;
	end
	assign fault_status = status_ff;

	AST_P2_CC1_FAULT: assert property (
		@(posedge clock) disable iff (!rst_n)
		p2_cc1_supply_en && !sense_ff[2] |=> fault_status[`FAULT_P2_CC1]
	) else $error("p2 cc1 fault not latched");
	AST_P2_CC2_FAULT: assert property (
		@(posedge clock) disable iff (!rst_n)
		p2_cc2_supply_en && !sense_ff[3] |=> fault_status[`FAULT_P2_CC2]
	) else $error("p2 cc2 fault not latched");
	AST_P1_CC1_FAULT: assert property (
		@(posedge clock) disable iff (!rst_n)
		fault_live[`FAULT_P1_CC1] |-> p1_cc1_supply_en && !sense_ff[0]
	) else $error("p1 cc1 fault without cause");
	AST_P1_CC2_FAULT: assert property (
		@(posedge clock) disable iff (!rst_n)
		p1_cc2_supply_en && !sense_ff[1] |-> fault_live[`FAULT_P1_CC2]
	) else $error("p1 cc2 fault missed");
	AST_P1_SUPPLY: assert property (
		@(posedge clock) disable iff (!rst_n)
		p1_ctrl.cc1_on |=> p1_cc1_supply_en
	) else $error("p1 cc1 supply not on");
	AST_P2_SUPPLY: assert property (
		@(posedge clock) disable iff (!rst_n)
		!p2_ctrl.cc2_on |=> !p2_cc2_supply_en
	) else $error("p2 cc2 supply not off");
	sequence drain_start_s;
		!p1_vbus_drain_en ##1 p1_vbus_drain_en;
	endsequence
	AST_P1_DRAIN_LEN: assert property (
		@(posedge clock) disable iff (!rst_n)
		drain_start_s |-> p1_vbus_drain_en [*8]
	) else $error("p1 drain pulse too short");
	AST_P2_DRAIN_START: assert property (
		@(posedge clock) disable iff (!rst_n)
		!p2_vbus_drain_en && p2_ctrl.drain_req |=> p2_vbus_drain_en
	) else $error("p2 drain not started");

	// counts how long the port 2 drain has been on, for the length check
	logic [`DRAIN_CNT_W-1:0] p2_drain_run_ff;
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n)
			p2_drain_run_ff <= '0;
		else if (p2_vbus_drain_en)
			p2_drain_run_ff <= p2_drain_run_ff + `DRAIN_CNT_W'(1);
		else
			p2_drain_run_ff <= '0;
	end
	AST_P2_DRAIN_LEN: assert property (
		@(posedge clock) disable iff (!rst_n)
		$fell(p2_vbus_drain_en)
		|-> p2_drain_run_ff == `DRAIN_CNT_W'(DRAIN_CYCLES)
	) else $error("p2 drain pulse length wrong");
	AST_P4_DISABLED: assert property (
		@(posedge clock) disable iff (!rst_n)
		!p4_port_enable |=> p4_power_en_oc_sense_oe
		&& !p4_power_en_oc_sense_out && !p4_power_en_oc_sense_pu
	) else $error("p4 pin not driven low");
	AST_P4_ENABLED: assert property (
		@(posedge clock) disable iff (!rst_n)
		p4_port_enable |=> !p4_power_en_oc_sense_oe
		&& p4_power_en_oc_sense_pu && p4_usb2_power_on && p4_usb3_power_on
	) else $error("p4 pin not input with pull-up");
	AST_P4_OC: assert property (
		@(posedge clock) disable iff (!rst_n)
		p4_power_en_oc_sense_pu && !sense_ff[4] |=> fault_status[`FAULT_P4_OC]
	) else $error("p4 overcurrent not latched");
	// a clear arriving with a live fault must not hide that fault
	AST_STATUS_SET: assert property (
		@(posedge clock) disable iff (!rst_n)
		fault_live != '0
		|=> (fault_status & $past(fault_live)) == $past(fault_live)
	) else $error("live fault not held in status");
	AST_STATUS_CLEAR: assert property (
		@(posedge clock) disable iff (!rst_n)
		(fault_clear & ~fault_live) != '0
		|=> (fault_status & $past(fault_clear) & ~$past(fault_live)) == '0
	) else $error("status bit not cleared");
endmodule : port_power_vconn_control

// ==== include/port_power_params.svh ====
// constants for the port power and supply control block
`ifndef PORT_POWER_PARAMS_SVH
`define PORT_POWER_PARAMS_SVH
`define DRAIN_TIME_US 10
`define CLK_MHZ 100
`define DRAIN_CYCLES (`DRAIN_TIME_US * `CLK_MHZ)
`define DRAIN_CNT_W 16
`define FAULT_P1_CC1 0
`define FAULT_P1_CC2 1
`define FAULT_P2_CC1 2
`define FAULT_P2_CC2 3
`define FAULT_P4_OC 4
`define FAULT_W 5
`endif

// ==== include/port_power_pkg.sv ====
// types for the port power and supply control block
package port_power_pkg;
	typedef struct packed {
		logic cc1_on;
		logic cc2_on;
		logic drain_req;
	} cc_port_ctrl_t;
	typedef struct packed {
		logic cc1_above_3v0;
		logic cc2_above_3v0;
	} cc_port_sense_t;
	typedef struct packed {
		logic cc1_supply_en;
		logic cc2_supply_en;
		logic vbus_drain_en;
	} cc_port_pins_t;
	typedef enum logic [1:0] {
		DRAIN_IDLE = 2'b01,
		DRAIN_BUSY = 2'b10
	} drain_state_t;
endpackage : port_power_pkg

// ==== test/test_port_power_vconn_control.sv ====
// self-checking bench for the port power and supply control block
`timescale 1ns/1ps
`include "port_power_params.svh"
module test_port_power_vconn_control import port_power_pkg::*;;
	localparam int DRAIN = 10;
	logic clock = 1'b0, reset_n = 1'b0, en4 = 1'b0, oc = 1'b0, chk = 1'b0;
	cc_port_ctrl_t p1_ctrl = '0, p2_ctrl = '0;
	cc_port_sense_t p1_sense, p2_sense;
	logic [3:0] fail = '0;
	logic [`FAULT_W-1:0] fault_clear = '0, fault_status, fault_live;
	logic p1a, p1b, p1d, p2a, p2b, p2d, oe, out, pu, u2, u3, pin;
	logic [20:0] q[$];
	int failures = 0, tests_run = 0;
	wire [20:0] obs = {p1a, p1b, p1d, p2a, p2b, p2d, oe, pu, u2, u3, out,
		fault_status, fault_live};
	port_power_vconn_control #(.DRAIN_CYCLES(DRAIN)) uut (.clock(clock),
		.reset_n(reset_n), .p1_ctrl(p1_ctrl), .p2_ctrl(p2_ctrl),
		.p1_sense(p1_sense), .p2_sense(p2_sense), .p4_port_enable(en4),
		.fault_clear(fault_clear), .p1_cc1_supply_en(p1a),
		.p1_cc2_supply_en(p1b), .p1_vbus_drain_en(p1d),
		.p2_cc1_supply_en(p2a), .p2_cc2_supply_en(p2b),
		.p2_vbus_drain_en(p2d), .p4_power_en_oc_sense_in(pin),
		.p4_power_en_oc_sense_out(out), .p4_power_en_oc_sense_oe(oe),
		.p4_power_en_oc_sense_pu(pu), .p4_usb2_power_on(u2),
		.p4_usb3_power_on(u3), .fault_status(fault_status),
		.fault_live(fault_live));
	vconn_partner far (.clock(clock), .supply_en({p2b, p2a, p1b, p1a}),
		.fail(fail), .oc(oc), .oe(oe), .out(out), .pu(pu),
		.p1_sense(p1_sense), .p2_sense(p2_sense), .pin(pin));
	function automatic logic [20:0] want(logic [1:0] d, logic [4:0] st,
		logic [4:0] lv);
		return {p1_ctrl.cc1_on, p1_ctrl.cc2_on, d[1], p2_ctrl.cc1_on,
			p2_ctrl.cc2_on, d[0], ~en4, en4, en4, en4, 1'b0, st, lv};
	endfunction : want
	function automatic logic [4:0] live();
		return {en4 & oc, fail & {p2_ctrl.cc2_on, p2_ctrl.cc1_on,
			p1_ctrl.cc2_on, p1_ctrl.cc1_on}};
	endfunction : live
	task automatic tick(int n);
		repeat (n) @(posedge clock);
		#1;
	endtask : tick
	task automatic expect_out(logic [20:0] w);
		q.push_back(w);
		chk = 1'b1;
		tick(1);
		chk = 1'b0;
	endtask : expect_out
	task automatic clear_all();
		fault_clear = 5'h1f;
		tick(1);
		fault_clear = '0;
		tick(5);
	endtask : clear_all
	task automatic check(logic [20:0] seen, logic [20:0] exp);
		tests_run++;
		if (seen !== exp) begin
			failures++;
			$display("unexpected outputs: expected %h seen %h", exp, seen);
		end
	endtask : check
	task automatic conclude();
		$display("comparisons %0d mismatches %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : conclude
	// the watcher looks mid-cycle, once registered outputs have settled
	always @(negedge clock) if (chk) begin
		check(obs, q.pop_front());
	end
	initial begin
		forever #5 clock = ~clock;
	end
	initial begin
		#100000;
		failures++;
		conclude();
	end
	initial begin
		logic [4:0] lv;
		void'($urandom(94788));
		repeat (8) @(posedge clock);
		#1 reset_n = 1'b1;
		tick(3);
		expect_out(want(2'b00, '0, '0));
		$display("reset test done");
		repeat (24) begin
			{p1_ctrl.cc1_on, p1_ctrl.cc2_on, p2_ctrl.cc1_on, p2_ctrl.cc2_on,
				en4, oc, fail} = 10'($urandom);
			// turn-on glitches before sense settles are cleared first
			tick(6);
			clear_all();
			lv = live();
			expect_out(want(2'b00, lv, lv));
			{oc, fail} = '0;
			tick(6);
			expect_out(want(2'b00, lv, '0));
			clear_all();
			expect_out(want(2'b00, '0, '0));
		end
		$display("supply and fault test done");
		p1_ctrl.drain_req = 1'b1;
		p2_ctrl.drain_req = 1'b1;
		tick(1);
		p1_ctrl.drain_req = 1'b0;
		p2_ctrl.drain_req = 1'b0;
		expect_out(want(2'b11, '0, '0));
		p1_ctrl.drain_req = 1'b1;
		tick(1);
		p1_ctrl.drain_req = 1'b0;
		tick(DRAIN - 3);
		expect_out(want(2'b11, '0, '0));
		expect_out(want(2'b00, '0, '0));
		$display("drain test done");
		conclude();
	end
endmodule : test_port_power_vconn_control

// ==== test/vconn_partner.sv ====
// far side model: vconn switches, cc sensing, port 4 current monitor
`timescale 1ns/1ps
module vconn_partner import port_power_pkg::*; (
	input wire logic clock,
	input wire logic [3:0] supply_en,
	input wire logic [3:0] fail,
	input wire logic oc,
	input wire logic oe,
	input wire logic out,
	input wire logic pu,
	output cc_port_sense_t p1_sense,
	output cc_port_sense_t p2_sense,
	output logic pin
);
	logic float_ff = 1'b0;
	// a cc line rises above 3.0V only while its switch is on and healthy
	wire [3:0] above = supply_en & ~fail;
	assign p1_sense = {above[0], above[1]};
	assign p2_sense = {above[2], above[3]};
	// an unpulled, undriven pin wanders rather than keeping its last level
	always @(posedge clock) float_ff <= ~float_ff;
	assign pin = oc ? 1'b0 : oe ? out : pu ? 1'b1 : float_ff;
endmodule : vconn_partner
